// File: spq_spi_cmd.sv
// Purpose: slave side of the spi register command protocol with apb control
// Assumes: spi mode 0, master bytes spaced widely against core_clk
// Notes:   register access leaves through a request/ack port to the core
//
// Notes on behaviour
// - header byte one bits 7:6: 00 read, 10 write, others reserved
// - header bits 5:4 size: 1, 2, 4 or 8 bytes
// - address high nibble in byte one, low byte in byte two
// - device shifts out 0xc1 then 0xc2 during the header
// - write data and checksum bytes are answered with 0x41
// - values travel least significant byte first
// - sync bytes answer 0x4e while busy, 0x41 when done
// - timeout count starts after byte one of the header
// - timeout count stops and clears after the last transaction byte
// - count past the limit drops the transaction back to idle
// - timeout limit programmable, default 320 ms
// - master appends checksum to writes, device to reads
// - checksum byte only expected while checksum enable is set
// - crc8 poly x8+x5+x4+1 over header and data, not sync
// - write with a wrong checksum updates nothing
// - length comes only from size field and checksum enable
// - extra bytes ignored while busy, else start a new header
// - too few bytes: wait for timeout, then drop
// - compute done set by hardware, cleared only by the master
// - read sends 0x4e bytes then one 0x41 before data
// - next header accepted right after final ack, no select toggle
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "spq_consts.svh"
module spq_spi_cmd #(
    parameter int unsigned MS_CYCLES = `SPQ_MS_CYCLES
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // spi pins
    input  wire logic              sclk,
    input  wire logic              csN,
    input  wire logic              mosi,
    output var  logic              miso,
    output var  logic              misoOe,
    // core register port
    output var  spq_pkg::spq_req_s regReq,
    output var  logic              regReqValid,
    input  wire logic              regAck,
    input  wire logic [63:0]       regRdata,
    // compute engine
    input  wire logic              computeDone
);
    import spq_pkg::*;

    function automatic logic [7:0] crcByte(input logic [7:0] crc, input logic [7:0] b);
        logic [7:0] c;
        c = crc ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `SPQ_CSUM_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [1:0] regSel(input logic [11:0] a);
        case (a)
            `SPQ_OFF_OPTIONS: regSel = 2'h1;
            `SPQ_OFF_TIMEOUT: regSel = 2'h2;
            `SPQ_OFF_STATUS:  regSel = 2'h3;
            default:          regSel = 2'h0;
        endcase
    endfunction

    // apb and configuration
    logic [31:0] prdataFf;
    logic        preadyFf;
    logic        pslverrFf;
    logic        csumEnFf;
    logic [15:0] limitMsFf;
    logic        doneFlagFf;
    logic        dropSeenFf;
    // spi synchronisers
    logic        sclkS1Ff, sclkS2Ff, sclkS3Ff;
    logic        csS1Ff, csS2Ff;
    logic        mosiS1Ff, mosiS2Ff;
    // byte engine
    logic [2:0]  bitCntFf;
    logic [6:0]  rxShiftFf;
    logic [7:0]  txByteFf;
    logic        misoFf;
    logic        misoOeFf;
    // protocol
    spq_state_e  stateFf;
    logic [1:0]  opFf;
    logic [1:0]  sizeFf;
    logic [3:0]  addrHiFf;
    logic [2:0]  idxFf;
    logic [63:0] dataFf;
    logic [7:0]  crcFf;
    logic        reqPendFf;
    logic        ackSentFf;
    spq_req_s    reqFf;
    logic        reqValidFf;
    logic        timingFf;
    logic [31:0] preFf;
    logic [15:0] msCntFf;

    logic        apbAccess;
    logic        apbDone;
    logic        rise;
    logic        byteDone;
    logic [7:0]  rxByte;
    logic        lastData;
    logic        timeout;
    logic        endTxn;
    logic        startTime;

    assign apbAccess = psel & penable & ~preadyFf;
    assign apbDone   = psel & penable & preadyFf;
    assign rise      = sclkS2Ff & ~sclkS3Ff;
    assign byteDone  = rise & ~csS2Ff & (bitCntFf == 3'h7);
    assign rxByte    = {rxShiftFf, mosiS2Ff};
    assign lastData  = (idxFf == 3'((4'h1 << sizeFf) - 4'h1));
    assign timeout   = timingFf && (msCntFf > limitMsFf);
    assign startTime = byteDone && (stateFf == ST_HDR0);

    // end of transaction: last data or checksum byte of the frame
    always_comb begin
        endTxn = 1'b0;
        if (byteDone) begin
            case (stateFf)
                ST_WDATA: endTxn = lastData && !csumEnFf;
                ST_WCSUM: endTxn = 1'b1;
                ST_RDATA: endTxn = !ackSentFf || (lastData && !csumEnFf);
                default:  endTxn = 1'b0;
            endcase
        end
    end

    // apb slave: one wait state, pready from a flop
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            preadyFf  <= 1'b0;
            pslverrFf <= 1'b0;
            prdataFf  <= 32'h0;
        end else begin
            preadyFf  <= apbAccess;
            pslverrFf <= apbAccess && (regSel(paddr) == 2'h0);
            if (apbAccess && !pwrite) begin
                case (regSel(paddr))
                    2'h1:    prdataFf <= {31'h0, csumEnFf};
                    2'h2:    prdataFf <= {16'h0, limitMsFf};
                    2'h3:    prdataFf <= {29'h0, dropSeenFf, stateFf != ST_HDR0, doneFlagFf};
                    default: prdataFf <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            csumEnFf  <= 1'b0;
            limitMsFf <= `SPQ_TIMEOUT_MS_RST;
        end else if (apbDone && pwrite) begin
            if (regSel(paddr) == 2'h1) begin
                csumEnFf <= pwdata[`SPQ_OPT_CSUM_BIT];
            end
            if (regSel(paddr) == 2'h2) begin
                limitMsFf <= pwdata[15:0];
            end
        end
    end

    // sticky flags: write one to clear, a new event wins over the clear
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            doneFlagFf <= 1'b0;
            dropSeenFf <= 1'b0;
        end else begin
            if (computeDone) begin
                doneFlagFf <= 1'b1;
            end else if (apbDone && pwrite && regSel(paddr) == 2'h3
                         && pwdata[`SPQ_STAT_DONE_BIT]) begin
                doneFlagFf <= 1'b0;
            end
            if (timeout) begin
                dropSeenFf <= 1'b1;
            end else if (apbDone && pwrite && regSel(paddr) == 2'h3
                         && pwdata[`SPQ_STAT_DROP_BIT]) begin
                dropSeenFf <= 1'b0;
            end
        end
    end

    // two flops on every pin; edge detect reads only the second and third
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            {sclkS1Ff, sclkS2Ff, sclkS3Ff} <= 3'h0;
            {csS1Ff, csS2Ff}               <= 2'h3;
            {mosiS1Ff, mosiS2Ff}           <= 2'h0;
        end else begin
            sclkS1Ff <= sclk;
            sclkS2Ff <= sclkS1Ff;
            sclkS3Ff <= sclkS2Ff;
            csS1Ff   <= csN;
            csS2Ff   <= csS1Ff;
            mosiS1Ff <= mosi;
            mosiS2Ff <= mosiS1Ff;
        end
    end

    // bit shifter; miso changes just after the sampling edge, mode 0
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bitCntFf  <= 3'h0;
            rxShiftFf <= 7'h0;
            misoFf    <= 1'b0;
            misoOeFf  <= 1'b0;
        end else begin
            misoOeFf <= ~csS2Ff;
            misoFf   <= txByteFf[3'h7 - bitCntFf];
            if (csS2Ff) begin
                bitCntFf <= 3'h0;
            end else if (rise) begin
                bitCntFf  <= bitCntFf + 3'h1;
                rxShiftFf <= rxByte[6:0];
            end
        end
    end

    // timeout: millisecond prescaler and millisecond count
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            timingFf <= 1'b0;
            preFf    <= 32'h0;
            msCntFf  <= 16'h0;
        end else if (startTime) begin
            timingFf <= 1'b1;
            preFf    <= 32'h0;
            msCntFf  <= 16'h0;
        end else if (endTxn || timeout) begin
            timingFf <= 1'b0;
            preFf    <= 32'h0;
            msCntFf  <= 16'h0;
        end else if (timingFf) begin
            if (preFf == MS_CYCLES - 1) begin
                preFf   <= 32'h0;
                msCntFf <= msCntFf + 16'h1;
            end else begin
                preFf <= preFf + 32'h1;
            end
        end
    end

    // core register request: held until the core acknowledges
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reqValidFf <= 1'b0;
            reqFf      <= '0;
        end else if (reqValidFf) begin
            if (regAck) begin
                reqValidFf <= 1'b0;
            end
        end else if (byteDone && stateFf == ST_HDR1) begin
            // writes need the address too; only a read is issued from the header
            reqValidFf <= (opFf == `SPQ_OP_READ);
            reqFf      <= '{write: 1'b0, size: sizeFf, addr: {addrHiFf, rxByte},
                            wdata: 64'h0};
        end else if (byteDone && stateFf == ST_WDATA && lastData && !csumEnFf) begin
            reqValidFf <= 1'b1;
            reqFf.write <= 1'b1;
            reqFf.wdata <= dataFf | (64'(rxByte) << {idxFf, 3'h0});
        end else if (byteDone && stateFf == ST_WCSUM && rxByte == crcFf) begin
            reqValidFf  <= 1'b1;
            reqFf.write <= 1'b1;
            reqFf.wdata <= dataFf;
        end
    end

    // protocol state and reply byte
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            stateFf   <= ST_HDR0;
            txByteFf  <= `SPQ_ECHO_FIRST;
            opFf      <= 2'h0;
            sizeFf    <= 2'h0;
            addrHiFf  <= 4'h0;
            idxFf     <= 3'h0;
            dataFf    <= 64'h0;
            crcFf     <= 8'h0;
            reqPendFf <= 1'b0;
            ackSentFf <= 1'b0;
        end else if (timeout) begin
            stateFf  <= ST_HDR0;
            txByteFf <= `SPQ_ECHO_FIRST;
        end else begin
            if (reqValidFf && regAck) begin
                reqPendFf <= 1'b0;
                if (!reqFf.write) begin
                    dataFf <= regRdata;
                end
            end
            if (byteDone) begin
                case (stateFf)
                    ST_HDR0: begin
                        opFf     <= rxByte[7:6];
                        sizeFf   <= rxByte[5:4];
                        addrHiFf <= rxByte[3:0];
                        crcFf    <= crcByte(8'h0, rxByte);
                        txByteFf <= `SPQ_ECHO_SECOND;
                        stateFf  <= ST_HDR1;
                    end
                    ST_HDR1: begin
                        crcFf <= crcByte(crcFf, rxByte);
                        idxFf <= 3'h0;
                        dataFf <= 64'h0;
                        ackSentFf <= 1'b0;
                        if (opFf == `SPQ_OP_WRITE) begin
                            txByteFf <= `SPQ_ACK_BYTE;
                            stateFf  <= ST_WDATA;
                        end else if (opFf == `SPQ_OP_READ) begin
                            reqPendFf <= 1'b1;
                            txByteFf  <= `SPQ_NAK_BYTE;
                            stateFf   <= ST_RSYNC;
                        end else begin
                            txByteFf <= `SPQ_NAK_BYTE;
                            stateFf  <= ST_DROP;
                        end
                    end
                    ST_WDATA: begin
                        dataFf <= dataFf | (64'(rxByte) << {idxFf, 3'h0});
                        crcFf  <= crcByte(crcFf, rxByte);
                        idxFf  <= idxFf + 3'h1;
                        if (!lastData) begin
                            txByteFf <= `SPQ_ACK_BYTE;
                        end else if (csumEnFf) begin
                            txByteFf <= `SPQ_ACK_BYTE;
                            stateFf  <= ST_WCSUM;
                        end else begin
                            reqPendFf <= 1'b1;
                            txByteFf  <= `SPQ_NAK_BYTE;
                            stateFf   <= ST_WSYNC;
                        end
                    end
                    ST_WCSUM: begin
                        reqPendFf <= (rxByte == crcFf);
                        txByteFf  <= (rxByte == crcFf) ? `SPQ_NAK_BYTE
                                                       : `SPQ_ACK_BYTE;
                        stateFf   <= ST_WSYNC;
                    end
                    ST_WSYNC: begin
                        // byte content is ignored while the write is busy
                        if (txByteFf == `SPQ_ACK_BYTE) begin
                            txByteFf <= `SPQ_ECHO_FIRST;
                            stateFf  <= ST_HDR0;
                        end else if (!reqPendFf) begin
                            txByteFf <= `SPQ_ACK_BYTE;
                        end
                    end
                    ST_RSYNC: begin
                        if (ackSentFf) begin
                            txByteFf <= dataFf[7:0];
                            crcFf    <= crcByte(crcFf, dataFf[7:0]);
                            idxFf    <= 3'h0;
                            stateFf  <= ST_RDATA;
                        end else if (!reqPendFf) begin
                            txByteFf  <= `SPQ_ACK_BYTE;
                            ackSentFf <= 1'b1;
                        end
                    end
                    ST_RDATA: begin
                        idxFf <= idxFf + 3'h1;
                        if (!ackSentFf) begin
                            txByteFf <= `SPQ_ECHO_FIRST;                      // checksum sent
                            stateFf  <= ST_HDR0;
                        end else if (!lastData) begin
                            txByteFf <= dataFf[{idxFf + 3'h1, 3'h0} +: 8];
                            crcFf    <= crcByte(crcFf, dataFf[{idxFf + 3'h1, 3'h0} +: 8]);
                        end else if (csumEnFf) begin
                            txByteFf <= crcFf;
                            ackSentFf <= 1'b0;                                // checksum byte next
                        end else begin
                            txByteFf <= `SPQ_ECHO_FIRST;
                            stateFf  <= ST_HDR0;
                        end
                    end
                    ST_DROP: txByteFf <= `SPQ_NAK_BYTE;
                    default: stateFf  <= ST_HDR0;
                endcase
            end
        end
    end

    assign prdata      = prdataFf;
    assign pready      = preadyFf;
    assign pslverr     = pslverrFf;
    assign miso        = misoFf;
    assign misoOe      = misoOeFf;
    assign regReq      = reqFf;
    assign regReqValid = reqValidFf;
endmodule // spq_spi_cmd
`default_nettype wire

// File: spq_consts.svh
// Purpose: constants of the spi register command port
// Assumes: core clock of 250 MHz
// Notes:   offsets are apb byte addresses
`ifndef SPQ_CONSTS_SVH
`define SPQ_CONSTS_SVH
`define SPQ_OFF_OPTIONS      12'h000
`define SPQ_OFF_TIMEOUT      12'h004
`define SPQ_OFF_STATUS       12'h008
`define SPQ_OPT_CSUM_BIT     0
`define SPQ_STAT_DONE_BIT    0
`define SPQ_STAT_BUSY_BIT    1
`define SPQ_STAT_DROP_BIT    2
`define SPQ_TIMEOUT_MS_RST   16'h0140
`define SPQ_ECHO_FIRST       8'hc1
`define SPQ_ECHO_SECOND      8'hc2
`define SPQ_ACK_BYTE         8'h41
`define SPQ_NAK_BYTE         8'h4e
`define SPQ_CSUM_POLY        8'h31
`define SPQ_OP_READ          2'h0
`define SPQ_OP_WRITE         2'h2
`define SPQ_CLK_MHZ          250
`define SPQ_MS_CYCLES        (`SPQ_CLK_MHZ * 1000)
`endif

// File: spq_pkg.sv
// Purpose: types of the spi register command port
// Assumes: nothing
// Notes:   register requests leave the block as one packed struct
package spq_pkg;
    typedef enum logic [2:0] {
        ST_HDR0, ST_HDR1, ST_WDATA, ST_WCSUM, ST_WSYNC, ST_RSYNC, ST_RDATA, ST_DROP
    } spq_state_e;
    typedef struct packed {
        logic        write;
        logic [1:0]  size;
        logic [11:0] addr;
        logic [63:0] wdata;
    } spq_req_s;
endpackage

// File: spq_host_model.sv
// Purpose: host side of the spi command link
// Assumes: spi mode 0, one byte per call
// Notes:   sclk stands low between bytes
`timescale 1ns/1ns
`default_nettype none
module spq_host_model (
    // pins driven by the host
    output logic      sclk,
    output logic      csN,
    output logic      mosi,
    // pins from the device
    input  wire logic miso,
    input  wire logic misoOe
);
    localparam int GAP_NS = 1700;

    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end

    task automatic select(input logic on);
        csN = !on;
        #500;
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi  = tx[i];
            #62;
            rx[i] = misoOe ? miso : 1'bx;
            sclk  = 1'b1;
            #63;
            sclk  = 1'b0;
        end
        // no pull on mosi: show the inverse so a stale bit cannot pass
        mosi = ~tx[0];
        #GAP_NS;
    endtask
endmodule // spq_host_model
`default_nettype wire

// File: spq_spi_cmd_chk.sv
// Purpose: port checks of the spi command block
// Assumes: one core clock domain
// Notes:   bound onto spq_spi_cmd
`timescale 1ns/1ns
`default_nettype none
`include "spq_consts.svh"
module spq_spi_cmd_chk #(
    parameter int unsigned MS_CYCLES = `SPQ_MS_CYCLES
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              resetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // link and core side
    input wire logic              misoOe,
    input wire spq_pkg::spq_req_s regReq,
    input wire logic              regReqValid,
    input wire logic              regAck,
    input wire logic              computeDone
);
    import spq_pkg::*;
    logic limSet_ff;
    logic donePend_ff;
    logic doneOld_ff;
    wire logic apbEnd = psel && penable && pready;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            limSet_ff <= 1'b0;
        end else if (apbEnd && pwrite && paddr == `SPQ_OFF_TIMEOUT) begin
            limSet_ff <= 1'b1;
        end
    end
    // lags the device by a cycle, so it only ever claims less than is set
    always_ff @(posedge core_clk) begin
        if (!resetn || (apbEnd && pwrite && paddr == `SPQ_OFF_STATUS && pwdata[0])) begin
            donePend_ff <= 1'b0;
        end else if (computeDone) begin
            donePend_ff <= 1'b1;
        end
        doneOld_ff <= donePend_ff && resetn;
    end

    property p_apb_wait; psel && penable && !pready |=> pready; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb access not answered");
    property p_unmapped; psel && penable && !pready && !pwrite && paddr == 12'h00c
        |=> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_limit_def; apbEnd && !pwrite && paddr == `SPQ_OFF_TIMEOUT && !limSet_ff
        |-> prdata == {16'h0, `SPQ_TIMEOUT_MS_RST}; endproperty
    a_limit_def: assert property (p_limit_def) else $error("timeout limit default wrong");
    property p_opt_bits; apbEnd && !pwrite && paddr == `SPQ_OFF_OPTIONS
        |-> prdata[31:1] == 31'h0; endproperty
    a_opt_bits: assert property (p_opt_bits) else $error("options unused bits set");
    property p_done_kept; apbEnd && !pwrite && paddr == `SPQ_OFF_STATUS && doneOld_ff
        |-> prdata[`SPQ_STAT_DONE_BIT]; endproperty
    a_done_kept: assert property (p_done_kept) else $error("compute done flag lost");
    property p_req_hold; regReqValid && !regAck |=> regReqValid && $stable(regReq); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
    property p_ack_drop; regReqValid && regAck |=> !regReqValid; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
    property p_reset_quiet; $rose(resetn) |-> !pready && !regReqValid && !misoOe; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule // spq_spi_cmd_chk

bind spq_spi_cmd spq_spi_cmd_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .misoOe(misoOe), .regReq(regReq), .regReqValid(regReqValid),
    .regAck(regAck), .computeDone(computeDone)
);
`default_nettype wire

// File: spq_spi_cmd_bench.sv
// Purpose: self-checking bench of the spi command block
// Assumes: host model drives the link, bench answers the core port
// Notes:   one ms is 20 core clocks here to keep timeouts short
`timescale 1ns/1ns
`default_nettype none
`include "spq_consts.svh"
module spq_spi_cmd_bench;
    import spq_pkg::*;
    localparam int ACK_WAIT = 900; // beyond one byte time, forces busy replies
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, errSeen, sclk, csN, mosi, miso, misoOe, regReqValid;
    spq_req_s    regReq, lastReq;
    logic        regAck = 1'b0;
    logic        computeDone = 1'b0;
    logic [63:0] regRdata = 64'h8877665544332211;
    logic [7:0]  rx, crc;
    logic [7:0]  oddHdr [3] = '{8'h40, 8'hc0, 8'h91};
    int          n_mismatch = 0, num_checks = 0, nReq = 0, waitCnt = 0;

    always #2 core_clk = ~core_clk;

    spq_spi_cmd #(.MS_CYCLES(20)) dut (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk(sclk), .csN(csN), .mosi(mosi),
        .miso(miso), .misoOe(misoOe), .regReq(regReq), .regReqValid(regReqValid),
        .regAck(regAck), .regRdata(regRdata), .computeDone(computeDone)
    );
    spq_host_model host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe));

    always @(posedge core_clk) begin
        regAck <= 1'b0;
        if (regReqValid === 1'b1 && !regAck) begin
            waitCnt <= waitCnt + 1;
            if (waitCnt == ACK_WAIT) begin
                regAck  <= 1'b1;
                waitCnt <= 0;
                nReq    <= nReq + 1;
                lastReq <= regReq;
            end
        end
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        c = c ^ b;
        for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ (c[7] ? `SPQ_CSUM_POLY : 8'h00);
        return c;
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge core_clk);
        if (i == 20) begin
            n_mismatch++;
            close_out();
        end
        q       = prdata;
        errSeen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tx(input logic [7:0] b, input logic [7:0] exp, input logic [7:0] cb);
        host.xfer(b, rx);
        check("reply byte", 64'(rx), 64'(exp));
        crc = crc8(crc, cb);
    endtask

    task automatic sync_ack(output int naks);
        for (naks = 0; naks < 12; naks++) begin
            host.xfer(8'hff, rx);
            if (rx === `SPQ_ACK_BYTE) break;
            check("sync byte", 64'(rx), 64'(`SPQ_NAK_BYTE));
        end
        if (naks == 12) begin
            n_mismatch++;
            close_out();
        end
    endtask

    task automatic xact(input logic [7:0] h0, input logic [7:0] h1, input logic [63:0] d,
                        input logic useCrc, input logic [7:0] flip);
        int n, k, n0;
        logic [63:0] m;
        n   = 1 << h0[5:4];
        m   = ~64'h0 >> (64 - 8 * n);
        n0  = nReq;
        crc = 8'h00;
        tx(h0, `SPQ_ECHO_FIRST, h0);
        tx(h1, `SPQ_ECHO_SECOND, h1);
        if (h0[7:6] == `SPQ_OP_WRITE) begin
            for (k = 0; k < n; k++) tx(d[8*k+:8], `SPQ_ACK_BYTE, d[8*k+:8]);
            if (useCrc) tx(crc ^ flip, `SPQ_ACK_BYTE, 8'h00);
            sync_ack(k);
            check("busy replies", 64'(k > 0), 64'(flip == 8'h00));
        end else begin
            sync_ack(k);
            for (k = 0; k < n; k++) tx(8'h00, d[8*k+:8], d[8*k+:8]);
            if (useCrc) tx(8'h00, crc, 8'h00);
        end
        check("request count", 64'(nReq - n0), 64'(flip == 8'h00));
        if (flip == 8'h00) begin
            check("request head", 64'({lastReq.write, lastReq.size, lastReq.addr}),
                  64'({h0[7], h0[5:4], h0[3:0], h1}));
            if (h0[7]) check("write data", lastReq.wdata & m, d & m);
        end
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        apb(1'b0, `SPQ_OFF_OPTIONS, 32'h0);
        check("options reset", 64'(q), 64'h0);
        apb(1'b0, `SPQ_OFF_TIMEOUT, 32'h0);
        check("limit reset", 64'(q), 64'(`SPQ_TIMEOUT_MS_RST));
        apb(1'b0, 12'h00c, 32'h0);
        check("unmapped error", 64'(errSeen), 64'h1);
        apb(1'b1, `SPQ_OFF_TIMEOUT, 32'h3e8);
        host.select(1'b1);
        xact(8'h91, 8'h23, 64'hbeef, 1'b0, 8'h00);
        xact(8'h2a, 8'h55, 64'h44332211, 1'b0, 8'h00);
        apb(1'b1, `SPQ_OFF_OPTIONS, 32'h1);
        xact(8'hb3, 8'h10, 64'h0123456789abcdef, 1'b1, 8'h00);
        xact(8'hb3, 8'h10, 64'h5a5a, 1'b1, 8'h01);
        xact(8'h3f, 8'hff, regRdata, 1'b1, 8'h00);
        apb(1'b1, `SPQ_OFF_OPTIONS, 32'h0);
        apb(1'b1, `SPQ_OFF_TIMEOUT, 32'h28);
        // reserved codes and a cut-short write; the limit lapses after byte two
        for (int j = 0; j < 3; j++) begin
            tx(oddHdr[j], `SPQ_ECHO_FIRST, 8'h00);
            tx(8'h00, `SPQ_ECHO_SECOND, 8'h00);
            apb(1'b0, `SPQ_OFF_STATUS, 32'h0);
            check("dropped and idle", 64'(q[2:1]), 64'h2);
            apb(1'b1, `SPQ_OFF_STATUS, 32'h4);
        end
        apb(1'b1, `SPQ_OFF_TIMEOUT, 32'h3e8);
        xact(8'h0a, 8'h07, 64'h11, 1'b0, 8'h00);
        @(posedge core_clk);
        computeDone <= 1'b1;
        @(posedge core_clk);
        computeDone <= 1'b0;
        apb(1'b0, `SPQ_OFF_STATUS, 32'h0);
        apb(1'b0, `SPQ_OFF_STATUS, 32'h0);
        check("done kept", 64'(q[0]), 64'h1);
        apb(1'b1, `SPQ_OFF_STATUS, 32'h1);
        apb(1'b0, `SPQ_OFF_STATUS, 32'h0);
        check("done cleared", 64'(q[0]), 64'h0);
        close_out();
    end
endmodule // spq_spi_cmd_bench
`default_nettype wire
